// ===== verilog/alr_pkg.sv
// Constants, carriers and states of the ambient light register bank
package alr_pkg;

	// ***********************************************
	// Bus address and command codes
	// ***********************************************
	localparam logic [6:0] SLAVE_ADDR  = 7'h10;
	localparam logic [7:0] CMD_CONFIG  = 8'h00;
	localparam logic [7:0] CMD_UPPER   = 8'h01;
	localparam logic [7:0] CMD_LOWER   = 8'h02;
	localparam logic [7:0] CMD_LOWPWR  = 8'h03;
	localparam logic [7:0] CMD_AMBIENT = 8'h04;
	localparam logic [7:0] CMD_WHITE   = 8'h05;
	localparam logic [7:0] CMD_STATUS  = 8'h06;
	localparam logic [7:0] CMD_IDENT   = 8'h07;

	// ***********************************************
	// Field positions, masks and reset values
	// ***********************************************
	localparam int GAIN_LSB      = 11;
	localparam int IT_LSB        = 6;
	localparam int PERS_LSB      = 4;
	localparam int EVEN_BIT      = 1;
	localparam int SD_BIT        = 0;
	localparam int LPM_LSB       = 1;
	localparam int LPE_BIT       = 0;
	localparam int LOW_FLAG_BIT  = 15;
	localparam int HIGH_FLAG_BIT = 14;
	localparam logic [15:0] CONFIG_MASK  = 16'h1bf3;
	localparam logic [15:0] LOWPWR_MASK  = 16'h0007;
	localparam logic [15:0] CONFIG_RESET = 16'h0001;
	localparam logic [15:0] BOUND_RESET  = 16'h0000;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [15:0] LOWPWR_RESET = 16'h0000;

	// ***********************************************
	// Carriers and states
	// ***********************************************
	typedef struct packed {
		logic [1:0] gain_select;
		logic [3:0] integration_time;
		logic [1:0] persistence_count;
		logic       event_enable;
		logic       shutdown_bit;
	} alr_cfg_t;

	typedef struct packed {
		logic [1:0] low_power_mode_select;
		logic       low_power_enable;
	} alr_lowpwr_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_CMD  = 3'b010,
		ST_WLO  = 3'b011,
		ST_WHI  = 3'b100,
		ST_RLO  = 3'b101,
		ST_RHI  = 3'b110,
		ST_DONE = 3'b111
	} alr_state_t;

endpackage

// ===== verilog/alr_window_detect.sv
// Threshold window comparator with persistence filter
`timescale 1ns/1ps
module alr_window_detect #(
	parameter int CNT_W = 4
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// New sample
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample,
	// Settings
	input  wire logic        event_enable,
	input  wire logic [15:0] upper_bound,
	input  wire logic [15:0] lower_bound,
	input  wire logic [1:0]  persistence_count,
	// Event pulses
	output logic             high_hit,
	output logic             low_hit
);

	logic [CNT_W-1:0] need;
	logic [1:0]       exceed;
	logic [1:0]       hit_reg;
	logic [1:0]       hit_next;
	logic [CNT_W-1:0] cnt_reg  [2];
	logic [CNT_W-1:0] cnt_next [2];

	// Required run length: 1, 2, 4 or 8
	// persistence run length
	assign need     = CNT_W'(1) << persistence_count;
	assign exceed   = {sample < lower_bound, sample > upper_bound};
	assign high_hit = hit_reg[0];
	assign low_hit  = hit_reg[1];

	// One counter per direction, index 0 high and 1 low
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_dir
			always_comb begin
				cnt_next[g] = cnt_reg[g];
				hit_next[g] = 1'b0;
				if (!event_enable) begin
					cnt_next[g] = '0;
				end else if (sample_valid) begin
					if (!exceed[g]) begin
						cnt_next[g] = '0;
					end else if (cnt_reg[g] + CNT_W'(1) >= need) begin
						hit_next[g] = 1'b1;
						cnt_next[g] = '0;
					end else begin
						cnt_next[g] = cnt_reg[g] + CNT_W'(1);
					end
				end
			end

			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					cnt_reg[g] <= '0;
					hit_reg[g] <= 1'b0;
				end else begin
					cnt_reg[g] <= cnt_next[g];
					hit_reg[g] <= hit_next[g];
				end
			end
		end
	endgenerate

	// ***********************************************
	// Checks
	// ***********************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_event_off_quiet: assert property (!event_enable |=> !high_hit && !low_hit)
		else $error("event reported while disabled");

	a_high_cause: assert property (high_hit |-> $past(sample_valid && sample > upper_bound))
		else $error("high event without exceeding sample");

endmodule

// ===== verilog/alr_register_bank.sv
// Register bank and serial bus slave of the ambient light sensor
// How it works
// - no event pin, status via bus only
// - code 00 is the configuration word
// - configuration resets to 0001, shut down
// - gain field bits 12:11
// - persistence 1,2,4,8 consecutive exceedances
// - bit 1 enables threshold events
// - bit 0 shuts measurement down
// - code 01 is the high bound
// - code 02 is the low bound
// - bounds only act while events enabled
// - power saving mode in bits 2:1
// - power saving enable in bit 0
// - code 04 returns the ambient result
// - code 05 returns the white result
// - code 06 returns the event status
// - bit 15 low crossing, bit 14 high
// - answers bus address 0x10 only
// - results kept in shutdown, refreshed after
`timescale 1ns/1ps
module alr_register_bank #(
	parameter logic [15:0] IDENT_WORD = 16'h5a3c // Arbitrary value
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// Serial bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Converter results
	input  wire logic        sample_valid,
	input  wire logic [15:0] ambient_sample,
	input  wire logic [15:0] white_sample,
	// Front end controls
	output alr_pkg::alr_cfg_t    meas_cfg,
	output alr_pkg::alr_lowpwr_t lowpwr_cfg
);

	// ***********************************************
	// Pin synchronisers and bus conditions
	// ***********************************************
	logic scl_meta, scl_sync, scl_prev;
	logic sda_meta, sda_sync, sda_prev;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	// Two flops per pin, then one more for edges
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			{scl_meta, scl_sync, scl_prev} <= 3'h7;
			{sda_meta, sda_sync, sda_prev} <= 3'h7;
		end else begin
			{scl_meta, scl_sync, scl_prev} <= {scl_in, scl_meta, scl_sync};
			{sda_meta, sda_sync, sda_prev} <= {sda_in, sda_meta, sda_sync};
		end
	end

	// Edges and start/stop detection
	assign scl_rise  = scl_sync & ~scl_prev;
	assign scl_fall  = ~scl_sync & scl_prev;
	assign bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
	assign bus_stop  = scl_sync & scl_prev & ~sda_prev & sda_sync;

	// ***********************************************
	// Register state
	// ***********************************************
	logic [15:0] config_reg, config_next;
	logic [15:0] upper_reg, upper_next;
	logic [15:0] lower_reg, lower_next;
	logic [15:0] lowpwr_reg, lowpwr_next;
	logic [15:0] ambient_reg, ambient_next;
	logic [15:0] white_reg, white_next;
	logic [1:0]  flags_reg, flags_next;
	logic [15:0] status_word;
	logic [15:0] read_word;
	logic        high_hit, low_hit;

	// ***********************************************
	// Bus engine state
	// ***********************************************
	alr_pkg::alr_state_t state_reg, state_next;
	alr_pkg::alr_state_t pend_reg, pend_next;
	alr_pkg::alr_state_t target;
	logic [3:0]  bit_cnt_reg, bit_cnt_next;
	logic [7:0]  shift_reg, shift_next;
	logic [7:0]  cmd_reg, cmd_next;
	logic [7:0]  wr_lo_reg, wr_lo_next;
	logic [15:0] rd_word_reg, rd_word_next;
	logic        sda_low_reg, sda_low_next;
	logic        nack_reg, nack_next;
	logic        reading, active;
	logic [7:0]  out_byte;
	logic        wr_en;
	logic [15:0] wr_data;
	logic        rd_capture;
	logic        status_clr;

	// Open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe  = sda_low_reg;

	assign reading  = (state_reg == alr_pkg::ST_RLO) || (state_reg == alr_pkg::ST_RHI);
	assign active   = (state_reg != alr_pkg::ST_IDLE) && !bus_start && !bus_stop;
	assign target   = (reading && nack_reg) ? alr_pkg::ST_DONE : pend_reg;
	assign out_byte = (state_reg == alr_pkg::ST_RHI) ? rd_word_reg[15:8] : rd_word_reg[7:0];

	assign wr_en   = active && scl_fall && (bit_cnt_reg == 4'h8)
		&& (state_reg == alr_pkg::ST_WHI);
	assign wr_data = {shift_reg, wr_lo_reg};

	// Word is snapshotted when the low byte starts
	assign rd_capture = active && scl_fall && (bit_cnt_reg == 4'h9)
		&& (target == alr_pkg::ST_RLO);
	assign status_clr = rd_capture && (cmd_reg == alr_pkg::CMD_STATUS);

	// Read multiplexer, reserved bits read zero
	// status word on code 06
	always_comb begin
		case (cmd_reg)
			alr_pkg::CMD_CONFIG:  read_word = config_reg;
			alr_pkg::CMD_UPPER:   read_word = upper_reg;
			alr_pkg::CMD_LOWER:   read_word = lower_reg;
			alr_pkg::CMD_LOWPWR:  read_word = lowpwr_reg;
			alr_pkg::CMD_AMBIENT: read_word = ambient_reg;
			alr_pkg::CMD_WHITE:   read_word = white_reg;
			alr_pkg::CMD_STATUS:  read_word = status_word;
			alr_pkg::CMD_IDENT:   read_word = IDENT_WORD;
			default:              read_word = 16'h0000;
		endcase
	end

	// Byte engine: shift on rising, drive on falling
	always_comb begin
		state_next   = state_reg;
		pend_next    = pend_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next   = shift_reg;
		cmd_next     = cmd_reg;
		wr_lo_next   = wr_lo_reg;
		rd_word_next = rd_word_reg;
		sda_low_next = sda_low_reg;
		nack_next    = nack_reg;
		if (bus_start) begin
			state_next   = alr_pkg::ST_ADDR;
			bit_cnt_next = 4'h0;
			sda_low_next = 1'b0;
		end else if (bus_stop) begin
			state_next   = alr_pkg::ST_IDLE;
			sda_low_next = 1'b0;
		end else if (state_reg != alr_pkg::ST_IDLE) begin
			if (scl_rise) begin
				if (bit_cnt_reg < 4'h8) begin
					if (!reading) begin
						shift_next = {shift_reg[6:0], sda_sync};
					end
					bit_cnt_next = bit_cnt_reg + 4'h1;
				end else if (bit_cnt_reg == 4'h9 && reading) begin
					nack_next = sda_sync;
				end
			end else if (scl_fall) begin
				if (bit_cnt_reg == 4'h8) begin
					bit_cnt_next = 4'h9;
					sda_low_next = 1'b0;
					case (state_reg)
						alr_pkg::ST_ADDR: begin
							if (shift_reg[7:1] == alr_pkg::SLAVE_ADDR) begin
								sda_low_next = 1'b1;
								pend_next    = shift_reg[0] ? alr_pkg::ST_RLO
									: alr_pkg::ST_CMD;
							end else begin
								pend_next = alr_pkg::ST_IDLE;
							end
						end
						alr_pkg::ST_CMD: begin
							sda_low_next = 1'b1;
							cmd_next     = shift_reg;
							pend_next    = alr_pkg::ST_WLO;
						end
						alr_pkg::ST_WLO: begin
							sda_low_next = 1'b1;
							wr_lo_next   = shift_reg;
							pend_next    = alr_pkg::ST_WHI;
						end
						alr_pkg::ST_WHI: begin
							sda_low_next = 1'b1;
							pend_next    = alr_pkg::ST_DONE;
						end
						alr_pkg::ST_RLO: pend_next = alr_pkg::ST_RHI;
						alr_pkg::ST_RHI: pend_next = alr_pkg::ST_RLO;
						default:         pend_next = alr_pkg::ST_DONE;
					endcase
				end else if (bit_cnt_reg == 4'h9) begin
					bit_cnt_next = 4'h0;
					sda_low_next = 1'b0;
					state_next   = target;
					if (target == alr_pkg::ST_RLO) begin
						rd_word_next = read_word;
						sda_low_next = ~read_word[7];
					end else if (target == alr_pkg::ST_RHI) begin
						sda_low_next = ~rd_word_reg[15];
					end
				end else if (reading) begin
					sda_low_next = ~out_byte[3'(4'h7 - bit_cnt_reg)];
				end
			end
		end
	end

	// Bus engine registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg   <= alr_pkg::ST_IDLE;
			pend_reg    <= alr_pkg::ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 8'h00;
			cmd_reg     <= 8'h00;
			wr_lo_reg   <= 8'h00;
			rd_word_reg <= 16'h0000;
			sda_low_reg <= 1'b0;
			nack_reg    <= 1'b0;
		end else begin
			state_reg   <= state_next;
			pend_reg    <= pend_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg   <= shift_next;
			cmd_reg     <= cmd_next;
			wr_lo_reg   <= wr_lo_next;
			rd_word_reg <= rd_word_next;
			sda_low_reg <= sda_low_next;
			nack_reg    <= nack_next;
		end
	end

	// ***********************************************
	// Register file
	// ***********************************************
	// flags only reach the host by reads
	// low flag bit 15, high bit 14
	always_comb begin
		status_word = 16'h0000;
		status_word[alr_pkg::LOW_FLAG_BIT]  = flags_reg[1];
		status_word[alr_pkg::HIGH_FLAG_BIT] = flags_reg[0];
	end

	// Writes, result capture and flag set/clear
	always_comb begin
		config_next  = config_reg;
		upper_next   = upper_reg;
		lower_next   = lower_reg;
		lowpwr_next  = lowpwr_reg;
		ambient_next = ambient_reg;
		white_next   = white_reg;
		flags_next   = flags_reg;
		if (wr_en) begin
			case (cmd_reg)
				alr_pkg::CMD_CONFIG: config_next = wr_data & alr_pkg::CONFIG_MASK;
				alr_pkg::CMD_UPPER:  upper_next  = wr_data;
				alr_pkg::CMD_LOWER:  lower_next  = wr_data;
				alr_pkg::CMD_LOWPWR: lowpwr_next = wr_data & alr_pkg::LOWPWR_MASK;
				default:             config_next = config_reg;
			endcase
		end
		if (sample_valid && !meas_cfg.shutdown_bit) begin
			ambient_next = ambient_sample;
			white_next   = white_sample;
		end
		// Set wins over clear by read
		if (status_clr) begin
			flags_next = 2'h0;
		end
		if (high_hit) begin
			flags_next[0] = 1'b1;
		end
		if (low_hit) begin
			flags_next[1] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			config_reg  <= alr_pkg::CONFIG_RESET;
			upper_reg   <= alr_pkg::BOUND_RESET;
			lower_reg   <= alr_pkg::BOUND_RESET;
			lowpwr_reg  <= alr_pkg::LOWPWR_RESET;
			ambient_reg <= alr_pkg::RESULT_RESET;
			white_reg   <= alr_pkg::RESULT_RESET;
			flags_reg   <= 2'h0;
		end else begin
			config_reg  <= config_next;
			upper_reg   <= upper_next;
			lower_reg   <= lower_next;
			lowpwr_reg  <= lowpwr_next;
			ambient_reg <= ambient_next;
			white_reg   <= white_next;
			flags_reg   <= flags_next;
		end
	end

	// Field decode to front end
	// gain field
	assign meas_cfg.gain_select       = config_reg[alr_pkg::GAIN_LSB +: 2];
	assign meas_cfg.integration_time  = config_reg[alr_pkg::IT_LSB +: 4];
	assign meas_cfg.persistence_count = config_reg[alr_pkg::PERS_LSB +: 2];
	assign meas_cfg.event_enable      = config_reg[alr_pkg::EVEN_BIT];
	assign meas_cfg.shutdown_bit      = config_reg[alr_pkg::SD_BIT];
	assign lowpwr_cfg.low_power_mode_select = lowpwr_reg[alr_pkg::LPM_LSB +: 2];
	assign lowpwr_cfg.low_power_enable      = lowpwr_reg[alr_pkg::LPE_BIT];

	alr_window_detect #(
		.CNT_W(4)
	) u_detect (
		.sys_clk          (sys_clk),
		.sys_rst          (sys_rst),
		.sample_valid     (sample_valid && !meas_cfg.shutdown_bit),
		.sample           (ambient_sample),
		.event_enable     (meas_cfg.event_enable),
		.upper_bound      (upper_reg),
		.lower_bound      (lower_reg),
		.persistence_count(meas_cfg.persistence_count),
		.high_hit         (high_hit),
		.low_hit          (low_hit)
	);

	// ***********************************************
	// Checks
	// ***********************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_cfg_write;
		wr_en && cmd_reg == alr_pkg::CMD_CONFIG;
	endsequence

	a_cfg_reset_val: assert property ($past(sys_rst) |-> config_reg == 16'h0001)
		else $error("configuration not 0001 after reset");

	a_cfg_write_val: assert property (s_cfg_write |=> config_reg == ($past(wr_data) & 16'h1bf3))
		else $error("configuration write not stored");

	a_lp_write_val: assert property (wr_en && cmd_reg == 8'h03 |=> lowpwr_reg == {13'h0, $past(wr_data[2:0])})
		else $error("power saving write not stored");

	a_ro_write_ign: assert property (wr_en && cmd_reg >= 8'h04 && !sample_valid |=> $stable(ambient_reg) && $stable(white_reg))
		else $error("read-only word changed by write");

	a_result_hold: assert property (sample_valid && meas_cfg.shutdown_bit |=> $stable(ambient_reg))
		else $error("result changed during shutdown");

	a_result_load: assert property (sample_valid && !meas_cfg.shutdown_bit |=> ambient_reg == $past(ambient_sample) && white_reg == $past(white_sample))
		else $error("result not refreshed");

	a_flag_set: assert property (high_hit |=> status_word[14] ##1 status_word[14] || $past(status_clr))
		else $error("high crossing flag not set");

	a_addr_ack: assert property (scl_fall && active && state_reg == alr_pkg::ST_ADDR && bit_cnt_reg == 4'h8 && shift_reg[7:1] == 7'h10 |=> sda_oe)
		else $error("own address not acknowledged");

endmodule

// ===== testbench/alr_i2c_host.sv
// Serial bus host model that drives the register bank from the far side
`timescale 1ns/1ps
module alr_i2c_host (
	// Clock
	input  wire logic        sys_clk,
	// Bus lines
	input  wire logic        sda_line,
	output logic             scl_out,
	output logic             sda_pull,
	// Read results
	output logic             res_valid,
	output logic [15:0]      res_word
);
	// Idle bus: clock high, data released to its pull-up
	initial begin
		scl_out = 1'b1;
		sda_pull = 1'b0;
		res_valid = 1'b0;
		res_word = 16'h0000;
	end

	// Wait n clocks, then step just off the edge
	task automatic hw(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Start or repeated start; ends with the clock low
	task automatic start();
		sda_pull = 1'b0;
		hw(5);
		scl_out = 1'b1;
		hw(10);
		sda_pull = 1'b1;
		hw(10);
		scl_out = 1'b0;
		hw(2);
	endtask

	// Stop, leaving the bus idle
	task automatic stop();
		sda_pull = 1'b1;
		hw(8);
		scl_out = 1'b1;
		hw(10);
		sda_pull = 1'b0;
		hw(10);
	endtask

	// One bit: data settles long before the rise, sampled mid high phase
	task automatic bit_io(input logic b, output logic got);
		sda_pull = ~b;
		hw(8);
		scl_out = 1'b1;
		hw(5);
		got = sda_line;
		hw(5);
		scl_out = 1'b0;
		hw(2);
	endtask

	// Eight bits msb first, then the acknowledge bit
	task automatic byte_io(input logic [7:0] tx, input logic ack_tx,
		output logic [7:0] rx, output logic ack_rx);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(~ack_tx, g);
		ack_rx = ~g;
	endtask

	// Hand a result to the bench for one clock
	task automatic report(input logic [15:0] v);
		res_word = v;
		res_valid = 1'b1;
		hw(1);
		res_valid = 1'b0;
	endtask

	task automatic write_word(input logic [7:0] cmd, input logic [15:0] w);
		logic [7:0] r;
		logic       a;
		start();
		byte_io({alr_pkg::SLAVE_ADDR, 1'b0}, 1'b0, r, a);
		byte_io(cmd, 1'b0, r, a);
		byte_io(w[7:0], 1'b0, r, a);
		byte_io(w[15:8], 1'b0, r, a);
		stop();
	endtask

	// low byte acked, high byte refused
	task automatic read_word(input logic [7:0] cmd);
		logic [7:0] lo;
		logic [7:0] hi;
		logic [7:0] r;
		logic       a;
		start();
		byte_io({alr_pkg::SLAVE_ADDR, 1'b0}, 1'b0, r, a);
		byte_io(cmd, 1'b0, r, a);
		start();
		byte_io({alr_pkg::SLAVE_ADDR, 1'b1}, 1'b0, r, a);
		byte_io(8'hff, 1'b1, lo, a);
		byte_io(8'hff, 1'b0, hi, a);
		stop();
		report({hi, lo});
	endtask

	// Address byte alone; reports 1 when it was acknowledged
	task automatic probe_addr(input logic [7:0] adr);
		logic [7:0] r;
		logic       a;
		start();
		byte_io(adr, 1'b0, r, a);
		stop();
		report({15'h0000, a});
	endtask
endmodule

// ===== testbench/tb_alr_register_bank.sv
// Self-checking bench of the ambient light register bank
`timescale 1ns/1ps
module tb_alr_register_bank;
	localparam logic [15:0] ID_VAL = 16'h3c5a; // Arbitrary value
	logic                 sys_clk, sys_rst, scl, sda_line, sda_pull, sda_out, sda_oe;
	logic                 sample_valid, res_valid, probe;
	logic [15:0]          ambient_sample, white_sample, res_word;
	alr_pkg::alr_cfg_t    meas_cfg;
	alr_pkg::alr_lowpwr_t lowpwr_cfg;
	logic [31:0]          seed;
	logic [15:0]          exp_q[$];
	int                   fail_count, n_tests;

	// ***********************************************
	// Design, host and bus wire
	// ***********************************************
	alr_register_bank #(.IDENT_WORD(ID_VAL)) DUT (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .sample_valid(sample_valid),
		.ambient_sample(ambient_sample), .white_sample(white_sample),
		.meas_cfg(meas_cfg), .lowpwr_cfg(lowpwr_cfg));
	alr_i2c_host h (
		.sys_clk(sys_clk), .sda_line(sda_line), .scl_out(scl), .sda_pull(sda_pull),
		.res_valid(res_valid), .res_word(res_word));
	// Open-drain data line with pull-up
	assign sda_line = !sda_pull && !(sda_oe && !sda_out);

	// Clock of 40 ns
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// ***********************************************
	// Checking
	// ***********************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Oldest note against each result that appears
	always @(posedge sys_clk) begin
		if (res_valid === 1'b1 || probe === 1'b1) begin
			if (exp_q.size() == 0) begin
				fail_count++;
				$display("unexpected at %0t: seen %h expected none", $time, res_word);
			end else if (probe === 1'b1) begin
				check({3'h0, meas_cfg, lowpwr_cfg}, exp_q.pop_front());
			end else begin
				check(res_word, exp_q.pop_front());
			end
		end
	end

	task automatic give_verdict();
		if (fail_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge sys_clk);
		fail_count++;
		give_verdict();
	end

	// ***********************************************
	// Stimulus helpers
	// ***********************************************
	task automatic rnd(output logic [15:0] r);
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		r = seed[15:0];
	endtask

	task automatic note(input logic [15:0] e);
		exp_q.push_back(e);
	endtask

	// Port levels expected from a config word and a power word
	function automatic logic [15:0] exp_ports(input logic [15:0] c, input logic [15:0] p);
		return {3'h0, c[12:11], c[9:6], c[5:4], c[1], c[0], p[2:0]};
	endfunction

	task automatic show_ports();
		probe = 1'b1;
		h.hw(1);
		probe = 1'b0;
	endtask

	// One converter result with a random white value
	task automatic pulse(input logic [15:0] amb, output logic [15:0] wht);
		rnd(wht);
		ambient_sample = amb;
		white_sample = wht;
		sample_valid = 1'b1;
		h.hw(1);
		sample_valid = 1'b0;
		h.hw(2);
	endtask

	// ***********************************************
	// Main sequence
	// ***********************************************
	initial begin
		logic [15:0] v, w, a, b, wa;
		seed = 32'h9603ebbc;
		fail_count = 0;
		n_tests = 0;
		probe = 1'b0;
		sys_rst = 1'b1;
		sample_valid = 1'b0;
		rnd(ambient_sample);
		rnd(white_sample);
		repeat (16) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		h.hw(5);
		note(exp_ports(16'h0001, 16'h0000));
		show_ports();
		note(16'h0001);
		h.read_word(alr_pkg::CMD_CONFIG);
		// Every gain, persistence and power mode code; reserved bits written as zero
		for (int i = 0; i < 4; i++) begin
			rnd(v);
			rnd(w);
			rnd(a);
			rnd(b);
			v = (v & alr_pkg::CONFIG_MASK & 16'he7cf) | (16'(i) << 11) | (16'(i) << 4);
			w = (16'(i) << 1) | (w & 16'h0001);
			h.write_word(alr_pkg::CMD_CONFIG, v);
			h.write_word(alr_pkg::CMD_LOWPWR, w);
			h.write_word(alr_pkg::CMD_UPPER, a);
			h.write_word(alr_pkg::CMD_LOWER, b);
			note(exp_ports(v, w));
			show_ports();
			note(v);
			h.read_word(alr_pkg::CMD_CONFIG);
			note(w);
			h.read_word(alr_pkg::CMD_LOWPWR);
			note(a);
			h.read_word(alr_pkg::CMD_UPPER);
			note(b);
			h.read_word(alr_pkg::CMD_LOWER);
		end
		// Results held in shutdown, loaded once powered on
		h.write_word(alr_pkg::CMD_CONFIG, 16'h0001);
		rnd(a);
		pulse(a, w);
		note(16'h0000);
		h.read_word(alr_pkg::CMD_AMBIENT);
		h.write_word(alr_pkg::CMD_CONFIG, 16'h0000);
		pulse(a, wa);
		note(a);
		h.read_word(alr_pkg::CMD_AMBIENT);
		note(wa);
		h.read_word(alr_pkg::CMD_WHITE);
		h.write_word(alr_pkg::CMD_CONFIG, 16'h0001);
		rnd(v);
		pulse(v, w);
		note(a);
		h.read_word(alr_pkg::CMD_AMBIENT);
		// Writes to read-only words change nothing
		h.write_word(alr_pkg::CMD_WHITE, v);
		note(wa);
		h.read_word(alr_pkg::CMD_WHITE);
		h.write_word(alr_pkg::CMD_IDENT, v);
		note(ID_VAL);
		h.read_word(alr_pkg::CMD_IDENT);
		// Reset again in mid-run: ports, ambient result and high bound read back their reset values
		sys_rst = 1'b1;
		h.hw(3);
		sys_rst = 1'b0;
		h.hw(5);
		note(exp_ports(alr_pkg::CONFIG_RESET, alr_pkg::LOWPWR_RESET));
		show_ports();
		note(alr_pkg::RESULT_RESET);
		h.read_word(alr_pkg::CMD_AMBIENT);
		note(alr_pkg::BOUND_RESET);
		h.read_word(alr_pkg::CMD_UPPER);
		// Events with a run of two, then a run of one; an equal sample breaks the run
		h.write_word(alr_pkg::CMD_UPPER, 16'h8000);
		h.write_word(alr_pkg::CMD_LOWER, 16'h1000);
		h.write_word(alr_pkg::CMD_CONFIG, 16'h0012);
		pulse(16'h9000, w);
		pulse(16'h8000, w);
		pulse(16'h9000, w);
		note(16'h0000);
		h.read_word(alr_pkg::CMD_STATUS);
		pulse(16'h9000, w);
		note(16'h4000);
		h.read_word(alr_pkg::CMD_STATUS);
		note(16'h0000);
		h.read_word(alr_pkg::CMD_STATUS);
		h.write_word(alr_pkg::CMD_CONFIG, 16'h0002);
		pulse(16'h0800, w);
		note(16'h8000);
		h.read_word(alr_pkg::CMD_STATUS);
		h.write_word(alr_pkg::CMD_CONFIG, 16'h0000);
		pulse(16'h0800, w);
		pulse(16'h9000, w);
		note(16'h0000);
		h.read_word(alr_pkg::CMD_STATUS);
		// Only the own address is acknowledged
		note(16'h0000);
		h.probe_addr(8'h22);
		note(16'h0001);
		h.probe_addr(8'h20);
		h.hw(5);
		if (exp_q.size() != 0) begin
			fail_count++;
		end
		give_verdict();
	end
endmodule
